// ### rtl/tmw_params.svh
/*
 * Constants of the 8-bit waveform timer: register offsets, field positions,
 * reset values and prescaler tap masks.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef TMW_PARAMS_SVH
`define TMW_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------------------
`define TMW_OFS_CTRL 8'h00
`define TMW_OFS_COUNT 8'h04
`define TMW_OFS_COMPARE 8'h08
`define TMW_OFS_FLAGS 8'h0c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TMW_CTRL_WAVE_LSB 0
`define TMW_CTRL_COM_LSB 2
`define TMW_CTRL_CS_LSB 4
`define TMW_CTRL_FORCE_BIT 7
`define TMW_FLAGS_OVF_BIT 0
`define TMW_FLAGS_CMF_BIT 1

// ----------------------------------------------------------------------------
// Reset values and counter extremes
// ----------------------------------------------------------------------------
`define TMW_RST_BYTE 8'h00
`define TMW_BOTTOM 8'h00
`define TMW_MAX 8'hff

// ----------------------------------------------------------------------------
// Prescaler: divider width and tap masks for /8, /64, /256 and /1024
// ----------------------------------------------------------------------------
`define TMW_DIV_W 10
`define TMW_MASK_DIV8 10'h007
`define TMW_MASK_DIV64 10'h03f
`define TMW_MASK_DIV256 10'h0ff
`define TMW_MASK_DIV1024 10'h3ff

`endif

// ### rtl/tmw_pkg.sv
/*
 * Types of the 8-bit waveform timer: waveform modes, output actions and
 * counting direction.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tmw_pkg;

   // Waveform mode field encodings.
   typedef enum logic [1:0] {
      TMW_NORMAL = 2'b00,
      TMW_PHASE = 2'b01,
      TMW_CTC = 2'b10,
      TMW_FAST = 2'b11
   } tmw_wave_type;

   // Action taken on the internal compare output state.
   typedef enum logic [1:0] {
      TMW_ACT_NONE = 2'b00,
      TMW_ACT_TOGGLE = 2'b01,
      TMW_ACT_CLEAR = 2'b10,
      TMW_ACT_SET = 2'b11
   } tmw_act_type;

   // Counting direction, used by the dual-slope mode only.
   typedef enum logic {
      TMW_UP = 1'b0,
      TMW_DOWN = 1'b1
   } tmw_dir_type;

endpackage : tmw_pkg

// ### rtl/tmw_prescale.sv
/*
 * Timer clock enable: a free-running prescaler with taps and an edge
 * detector on the external count input.
 * Assumes ext_clk_in is already synchronous to clk.
 */
`timescale 1ns/1ps
`include "tmw_params.svh"

module tmw_prescale #(
   parameter int unsigned DIV_W = `TMW_DIV_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [2:0] clock_select,
   input wire logic ext_clk_in,
   output logic timer_tick
);
   import tmw_pkg::*;

   // The divider must hold the widest tap.
   if (DIV_W < `TMW_DIV_W) begin : g_bad_width
      $error("tmw_prescale: DIV_W too small for the /1024 tap");
   end

   logic [DIV_W-1:0] div_r;
   logic ext_prev_r;

   // Free running: enabling a prescaled tap may wait up to a full divisor.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         div_r <= '0;
      else
         div_r <= div_r + 1'b1;
   end

   // Last sample of the external input, for edge detection.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ext_prev_r <= 1'b0;
      else
         ext_prev_r <= ext_clk_in;
   end

   // Tap select; a zero field stops the timer.
   // divisors one to 1024
   always_comb
   begin
      case (clock_select)
         3'h1: timer_tick = 1'b1;
         3'h2: timer_tick = (div_r[9:0] & `TMW_MASK_DIV8) == `TMW_MASK_DIV8;
         3'h3: timer_tick = (div_r[9:0] & `TMW_MASK_DIV64) == `TMW_MASK_DIV64;
         3'h4: timer_tick = (div_r[9:0] & `TMW_MASK_DIV256) == `TMW_MASK_DIV256;
         3'h5: timer_tick = (div_r[9:0] & `TMW_MASK_DIV1024) == `TMW_MASK_DIV1024;
         3'h6: timer_tick = ext_prev_r & ~ext_clk_in;
         3'h7: timer_tick = ~ext_prev_r & ext_clk_in;
         default: timer_tick = 1'b0;
      endcase
   end

endmodule : tmw_prescale

// ### rtl/tmw_timer.sv
/*
 * 8-bit timer/counter with one compare channel: normal, clear-on-compare,
 * fast PWM and phase correct PWM, with overflow and compare match flags,
 * reached over an APB slave.
 * Assumes a 100 MHz clk, APB signals synchronous to it, and an interrupt
 * controller that pulses the service inputs when it takes a vector.
 */
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tmw_params.svh"

module tmw_timer #(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned DIV_W = `TMW_DIV_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clk_in,
   input wire logic overflow_service,
   input wire logic compare_service,
   output logic compare_output,
   output logic compare_output_en,
   output logic overflow_flag,
   output logic compare_match_flag
);
   import tmw_pkg::*;

   // The decoder compares against eight-bit offsets.
   if (ADDR_W < 8) begin : g_bad_addr
      $error("tmw_timer: ADDR_W must be at least 8");
   end

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   tmw_wave_type wave_r;
   logic [1:0] com_r;
   logic [2:0] clock_select_r;
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   tmw_dir_type dir_r;
   tmw_dir_type dir_nxt;
   logic [7:0] cmp_buf_r;
   logic [7:0] cmp_active_r;
   logic block_r;
   logic oc_r;
   logic ovf_r;
   logic cmf_r;
   logic [31:0] prdata_r;
   logic timer_tick;
   logic wr_acc;
   logic wr_ctrl;
   logic wr_count;
   logic wr_cmp;
   logic wr_flags;
   logic mapped;
   logic is_pwm;
   logic at_max;
   logic match_ev;
   logic ovf_set;
   logic up_slope;
   logic force_ev;
   tmw_act_type act;
   logic [7:0] addr8;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------

   // Output action for the single-slope and non-PWM settings of the field.
   function automatic tmw_act_type match_act(input logic [1:0] com);
      case (com)
         2'b01: match_act = TMW_ACT_TOGGLE;
         2'b10: match_act = TMW_ACT_CLEAR;
         2'b11: match_act = TMW_ACT_SET;
         default: match_act = TMW_ACT_NONE;
      endcase
   endfunction : match_act

   // True for the two PWM waveform modes.
   function automatic logic pwm_mode(input logic [1:0] wave);
      pwm_mode = (wave == TMW_PHASE) || (wave == TMW_FAST);
   endfunction : pwm_mode

   // -------------------------------------------------------------------------
   // Timer clock enable
   // -------------------------------------------------------------------------
   tmw_prescale #(
      .DIV_W(DIV_W)
   ) u_prescale (
      .clk(clk),
      .reset_n(reset_n),
      .clock_select(clock_select_r),
      .ext_clk_in(ext_clk_in),
      .timer_tick(timer_tick)
   );

   // -------------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------------

   // Zero wait states; unmapped offsets answer with an error.
   assign addr8 = paddr[7:0];
   assign mapped = (paddr[ADDR_W-1:0] >> 8) == '0 &&
                   (addr8 == `TMW_OFS_CTRL || addr8 == `TMW_OFS_COUNT ||
                    addr8 == `TMW_OFS_COMPARE || addr8 == `TMW_OFS_FLAGS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_acc = psel & penable & pwrite & mapped;
   assign wr_ctrl = wr_acc && addr8 == `TMW_OFS_CTRL;
   assign wr_count = wr_acc && addr8 == `TMW_OFS_COUNT;
   assign wr_cmp = wr_acc && addr8 == `TMW_OFS_COMPARE;
   assign wr_flags = wr_acc && addr8 == `TMW_OFS_FLAGS;
   assign prdata = prdata_r;

   // Read data is captured in the setup phase so it stands in the access phase.
   // counter readable while stopped
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         prdata_r <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         case (addr8)
            `TMW_OFS_CTRL: prdata_r <= {24'h00_0000, 1'b0, clock_select_r, com_r, wave_r};
            `TMW_OFS_COUNT: prdata_r <= {24'h00_0000, count_r};
            `TMW_OFS_COMPARE: prdata_r <= {24'h00_0000, cmp_buf_r};
            `TMW_OFS_FLAGS: prdata_r <= {30'h0000_0000, cmf_r, ovf_r};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Control fields
   // -------------------------------------------------------------------------

   // A new output mode only steers the next match; the counter ignores it.
   // reset to stopped normal mode
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wave_r <= TMW_NORMAL;
         com_r <= 2'b00;
         clock_select_r <= 3'b000;
      end
      else if (wr_ctrl)
      begin
         wave_r <= tmw_wave_type'(pwdata[`TMW_CTRL_WAVE_LSB +: 2]);
         com_r <= pwdata[`TMW_CTRL_COM_LSB +: 2];
         clock_select_r <= pwdata[`TMW_CTRL_CS_LSB +: 3];
      end
   end

   // The force strobe only counts in the non-PWM mode being written.
   assign force_ev = wr_ctrl && pwdata[`TMW_CTRL_FORCE_BIT] &&
                     !pwm_mode(pwdata[`TMW_CTRL_WAVE_LSB +: 2]);
   assign is_pwm = pwm_mode(wave_r);
   assign at_max = count_r == `TMW_MAX;

   // -------------------------------------------------------------------------
   // Compare value, buffered in PWM modes
   // -------------------------------------------------------------------------

   // Software always sees the buffer; the comparator sees the active copy.
   // direct in non-PWM, buffered in PWM
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cmp_buf_r <= `TMW_RST_BYTE;
      else if (wr_cmp)
         cmp_buf_r <= pwdata[7:0];
   end

   // Loading at MAX keeps each PWM period of the intended length.
   // load at MAX in PWM modes
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cmp_active_r <= `TMW_RST_BYTE;
      else if (wr_cmp && !is_pwm)
         cmp_active_r <= pwdata[7:0];
      else if (is_pwm && timer_tick && at_max)
         cmp_active_r <= cmp_buf_r;
   end

   // -------------------------------------------------------------------------
   // Match detection
   // -------------------------------------------------------------------------

   // A counter write hides any match in the following timer cycle.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         block_r <= 1'b0;
      else if (wr_count)
         block_r <= 1'b1;
      else if (timer_tick)
         block_r <= 1'b0;
   end

   // a value below count is missed
   assign match_ev = timer_tick && !block_r && count_r == cmp_active_r;

   // -------------------------------------------------------------------------
   // Counter sequence
   // -------------------------------------------------------------------------

   // Next count and direction follow the waveform mode; in CTC the count also clears on a match.
   // sequence set by waveform mode
   always_comb
   begin
      count_nxt = count_r;
      dir_nxt = dir_r;
      if (timer_tick)
      begin
         case (wave_r)
            TMW_NORMAL: count_nxt = count_r + 8'h01;
            TMW_CTC: count_nxt = match_ev ? `TMW_BOTTOM : count_r + 8'h01;
            TMW_FAST: count_nxt = at_max ? `TMW_BOTTOM : count_r + 8'h01;
            TMW_PHASE:
            begin
               if (dir_r == TMW_UP)
               begin
                  if (at_max)
                  begin
                     dir_nxt = TMW_DOWN;
                     count_nxt = count_r - 8'h01;
                  end
                  else
                     count_nxt = count_r + 8'h01;
               end
               else if (count_r == `TMW_BOTTOM)
               begin
                  dir_nxt = TMW_UP;
                  count_nxt = count_r + 8'h01;
               end
               else
                  count_nxt = count_r - 8'h01;
            end
            default: count_nxt = count_r;
         endcase
      end
   end

   // A software write replaces whatever the sequence would do.
   // writable in any mode
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         count_r <= `TMW_RST_BYTE;
      else if (wr_count)
         count_r <= pwdata[7:0];
      else
         count_r <= count_nxt;
   end

   // Direction register, meaningful in dual-slope mode only.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         dir_r <= TMW_UP;
      else if (wave_r != TMW_PHASE)
         dir_r <= TMW_UP;
      else
         dir_r <= dir_nxt;
   end

   // -------------------------------------------------------------------------
   // Output waveform
   // -------------------------------------------------------------------------

   // At the turning points the slope is taken from the side just starting,
   // so a compare of BOTTOM or MAX gives a steady level.
   assign up_slope = (count_r == `TMW_BOTTOM) ? 1'b1 : at_max ? 1'b0 : (dir_r == TMW_UP);

   // Choose the action for this cycle; a force beats a real match.
   // field zero maps to no action
   always_comb
   begin
      act = TMW_ACT_NONE;
      if (force_ev)
         act = match_act(pwdata[`TMW_CTRL_COM_LSB +: 2]);
      else if (timer_tick)
      begin
         case (wave_r)
            TMW_NORMAL, TMW_CTC: if (match_ev) act = match_act(com_r);
            TMW_FAST:
            begin
               // BOTTOM edge wins over a match at MAX
               if (at_max && com_r[1])
                  act = com_r[0] ? TMW_ACT_CLEAR : TMW_ACT_SET;
               // clear or set on match; toggle
               else if (match_ev)
                  act = match_act(com_r);
            end
            TMW_PHASE:
            begin
               if (match_ev && com_r[1])
                  act = (up_slope ^ com_r[0]) ? TMW_ACT_CLEAR : TMW_ACT_SET;
            end
            default: act = TMW_ACT_NONE;
         endcase
      end
   end

   // Internal output state, kept across mode changes.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         oc_r <= 1'b0;
      else
      begin
         case (act)
            TMW_ACT_TOGGLE: oc_r <= ~oc_r;
            TMW_ACT_CLEAR: oc_r <= 1'b0;
            TMW_ACT_SET: oc_r <= 1'b1;
            default: oc_r <= oc_r;
         endcase
      end
   end

   // The pin takes the waveform only while the output mode is non-zero.
   // pin direction is software's job
   assign compare_output = oc_r;
   assign compare_output_en = com_r != 2'b00;

   // -------------------------------------------------------------------------
   // Flags
   // -------------------------------------------------------------------------

   assign ovf_set = timer_tick &&
                    ((wave_r != TMW_PHASE && at_max) ||
                     (wave_r == TMW_PHASE && dir_r == TMW_DOWN && count_r == 8'h01));

   // Set wins over a clear in the same cycle.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ovf_r <= 1'b0;
      else if (ovf_set)
         ovf_r <= 1'b1;
      else if (overflow_service || (wr_flags && pwdata[`TMW_FLAGS_OVF_BIT]))
         ovf_r <= 1'b0;
   end

   // flag at the tick ending the match cycle
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cmf_r <= 1'b0;
      else if (match_ev)
         cmf_r <= 1'b1;
      else if (compare_service || (wr_flags && pwdata[`TMW_FLAGS_CMF_BIT]))
         cmf_r <= 1'b0;
   end

   assign overflow_flag = ovf_r;
   assign compare_match_flag = cmf_r;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   stop_hold_a: assert property (clock_select_r == 3'h0 && !wr_count |=> $stable(count_r))
      else $error("counter moved while stopped");
   norm_wrap_a: assert property (timer_tick && wave_r == TMW_NORMAL && at_max && !wr_count
      |=> count_r == 8'h00 && ovf_r)
      else $error("normal mode did not wrap with overflow");
   ctc_clear_a: assert property (wave_r == TMW_CTC && match_ev && !wr_count
      |=> count_r == 8'h00)
      else $error("clear-on-compare did not clear");
   cmf_set_a: assert property (match_ev |=> cmf_r)
      else $error("compare flag not set after match");
   fast_clear_a: assert property (timer_tick && wave_r == TMW_FAST && at_max && !wr_count
      |=> count_r == 8'h00 && ovf_r)
      else $error("fast PWM did not restart at BOTTOM");
   // MAX stands for one tick, then the count steps back down to one below it.
   phase_turn_a: assert property (timer_tick && wave_r == TMW_PHASE && dir_r == TMW_UP &&
      count_r == 8'hfe && !wr_count ##1 (timer_tick && !wr_count && wave_r == TMW_PHASE)
      |=> count_r == 8'hfe && dir_r == TMW_DOWN)
      else $error("phase correct did not hold MAX once");
   wr_prio_a: assert property (wr_count |=> count_r == $past(pwdata[7:0]))
      else $error("counter write lost");
   com0_hold_a: assert property (match_ev && com_r == 2'b00 && !force_ev
      |=> $stable(oc_r))
      else $error("output changed with output mode zero");
   ctc_toggle_a: assert property (wave_r == TMW_CTC && match_ev && com_r == 2'b01
      && !force_ev |=> oc_r != $past(oc_r))
      else $error("output did not toggle on match");

endmodule : tmw_timer

// ### test/tmw_port_model.sv
/* Port pin and interrupt controller model for the waveform timer.
   Assumes the flags and the compare output come straight from the timer. */
`timescale 1ns/1ps
module tmw_port_model (
   input wire logic clk,
   input wire logic compare_output,
   input wire logic compare_output_en,
   input wire logic pin_dir_out,
   input wire logic service_en,
   input wire logic overflow_flag,
   input wire logic compare_match_flag,
   output logic pin_level,
   output logic overflow_service,
   output logic compare_service
);
   // pin direction gate.
   // An input pin floats to its pull-up, so a stale level never shows.
   assign pin_level = (pin_dir_out && compare_output_en) ? compare_output : 1'b1;
   // The controller takes a pending vector one cycle after it sees the flag.
   initial
   begin
      overflow_service = 1'b0;
      compare_service = 1'b0;
   end
   always @(posedge clk)
   begin
      overflow_service <= service_en && overflow_flag && !overflow_service;
      compare_service <= service_en && compare_match_flag && !compare_service;
   end
endmodule : tmw_port_model

// ### test/timer8_waveform_modes_bench.sv
/* Self-checking bench for the 8-bit waveform timer.
   Assumes a zero-wait APB slave and the port model on the far side. */
`timescale 1ns/1ps
`include "tmw_params.svh"
module timer8_waveform_modes_bench;
   import tmw_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic service_en = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, ovf_srv, cmp_srv, co, co_en, ovf, cmf, pin;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   int k, g;
   // The clock, and a cycle ceiling that cuts a hang short.
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   tmw_timer u_tmw_timer (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clk_in(1'b0), .overflow_service(ovf_srv),
      .compare_service(cmp_srv), .compare_output(co), .compare_output_en(co_en),
      .overflow_flag(ovf), .compare_match_flag(cmf));
   tmw_port_model u_tmw_port_model (.clk(clk), .compare_output(co), .compare_output_en(co_en),
      .pin_dir_out(1'b1), .service_en(service_en), .overflow_flag(ovf),
      .compare_match_flag(cmf), .pin_level(pin), .overflow_service(ovf_srv),
      .compare_service(cmp_srv));
   // Comparison, bus and measuring helpers.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [31:0] ctl(logic [2:0] cs, logic [1:0] com, tmw_wave_type w);
      return {25'h0, cs, com, w};
   endfunction : ctl
   // The request stands until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic gap(output int n);
      logic p;
      p = co;
      n = 0;
      while (co === p && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
   endtask : gap
   task automatic t_reset();
      @(negedge clk);
      check(32'({co, co_en, ovf, cmf, pready}), 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rd, 32'h0);
      end
      apb(1'b0, 8'h40, 32'h0);
      check(32'(err), 32'h1);
   endtask : t_reset
   // Forced actions while stopped; the count stays put with no clock.
   task automatic t_force();
      logic [1:0] com_t[3] = '{2'd3, 2'd0, 2'd1};
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, `TMW_OFS_CTRL, 32'h80 | ctl(3'd0, com_t[i], i == 2 ? TMW_CTC : TMW_NORMAL));
         @(negedge clk);
         check(32'(co), i == 2 ? 32'h0 : 32'h1);
      end
      check(32'({co_en, pin}), 32'h2);
      apb(1'b1, `TMW_OFS_COUNT, 32'h5a);
      repeat (20) @(posedge clk);
      apb(1'b0, `TMW_OFS_COUNT, 32'h0);
      check(rd, 32'h5a);
   endtask : t_force
   task automatic t_normal();
      apb(1'b1, `TMW_OFS_COUNT, 32'hfc);
      apb(1'b1, `TMW_OFS_FLAGS, 32'h3);
      apb(1'b1, `TMW_OFS_CTRL, ctl(3'd1, 2'd0, TMW_NORMAL));
      for (k = 0; ovf !== 1'b1 && k < 20; k++)
         @(negedge clk);
      check(32'(k >= 4 && k <= 5), 32'h1);
      apb(1'b1, `TMW_OFS_COUNT, 32'h80);
      apb(1'b0, `TMW_OFS_COUNT, 32'h0);
      check(32'(rd >= 32'h80 && rd <= 32'h83), 32'h1);
      @(posedge clk);
      service_en <= 1'b1;
      repeat (3) @(negedge clk);
      check(32'(ovf), 32'h0);
      @(posedge clk);
      service_en <= 1'b0;
   endtask : t_normal
   // Clear-on-compare toggling at every prescaler tap.
   task automatic t_ctc();
      int cs_t[6] = '{1, 1, 2, 3, 4, 5};
      int n_t[6] = '{4, 1, 8, 64, 256, 1024};
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, `TMW_OFS_CTRL, ctl(3'd0, 2'd1, TMW_CTC));
         apb(1'b1, `TMW_OFS_COMPARE, i == 0 ? 32'h3 : 32'h0);
         // A count write hides the next match, so start one step before the wrap.
         apb(1'b1, `TMW_OFS_COUNT, 32'hff);
         apb(1'b1, `TMW_OFS_FLAGS, 32'h3);
         apb(1'b1, `TMW_OFS_CTRL, ctl(3'(cs_t[i]), 2'd1, TMW_CTC));
         gap(g);
         gap(g);
         check(32'(g), 32'(n_t[i]));
         check(32'(cmf), 32'h1);
      end
   endtask : t_ctc
   // A compare below the count is missed until the counter wraps.
   task automatic t_miss();
      apb(1'b1, `TMW_OFS_CTRL, ctl(3'd0, 2'd0, TMW_CTC));
      apb(1'b1, `TMW_OFS_COMPARE, 32'h05);
      apb(1'b1, `TMW_OFS_COUNT, 32'h10);
      apb(1'b1, `TMW_OFS_FLAGS, 32'h3);
      @(negedge clk);
      check(32'({ovf, cmf}), 32'h0);
      apb(1'b1, `TMW_OFS_CTRL, ctl(3'd1, 2'd0, TMW_CTC));
      for (k = 0; cmf !== 1'b1 && k < 400; k++)
         @(negedge clk);
      check(32'(ovf), 32'h1);
      check(32'(k > 200 && k < 400), 32'h1);
      apb(1'b0, `TMW_OFS_FLAGS, 32'h0);
      check(rd, 32'h3);
   endtask : t_miss
   // High time over whole periods; settling covers the buffered compare.
   task automatic t_pwm();
      tmw_wave_type w_t[7] = '{TMW_FAST, TMW_FAST, TMW_FAST, TMW_FAST, TMW_FAST,
         TMW_PHASE, TMW_PHASE};
      logic [1:0] com_t[7] = '{2'd2, 2'd3, 2'd2, 2'd2, 2'd1, 2'd2, 2'd3};
      logic [31:0] cmp_t[7] = '{32'h40, 32'h40, 32'hff, 32'h0, 32'h40, 32'h40, 32'h40};
      int win_t[7] = '{512, 512, 512, 512, 512, 1020, 1020};
      int hi_t[7] = '{130, 382, 512, 2, 256, 256, 764};
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, `TMW_OFS_COMPARE, cmp_t[i]);
         apb(1'b0, `TMW_OFS_COMPARE, 32'h0);
         check(rd, cmp_t[i]);
         apb(1'b1, `TMW_OFS_CTRL, ctl(3'd1, com_t[i], w_t[i]));
         apb(1'b1, `TMW_OFS_FLAGS, 32'h3);
         repeat (600) @(posedge clk);
         g = 0;
         repeat (win_t[i])
         begin
            @(negedge clk);
            g += int'(co === 1'b1);
         end
         check(32'(g), 32'(hi_t[i]));
         check(32'(ovf), 32'h1);
      end
   endtask : t_pwm
   task automatic end_of_test();
      $display("Mismatches %0d in %0d comparisons", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // Main sequence after a four-cycle reset.
   initial
   begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_force();
      t_normal();
      t_ctc();
      t_miss();
      t_pwm();
      end_of_test();
   end
endmodule : timer8_waveform_modes_bench
